// ---- src/sfd_pkg.sv ----
/*
 * constants, carrier types and decode helpers for the serial flash
 * status / identification command decoder.
 * assumes: the host drives chip select, serial clock and the instruction,
 * address and dummy phases in spi mode 0 or 3, most significant bit first.
 */
// Function
// (R01) 05h reads status byte one, 1-0-1
// (R02) 35h reads status byte two, 1-0-1
// (R03) 15h reads status byte three, 1-0-1
// (R04) 01h writes status byte one, 1-0-1
// (R05) 31h writes status byte two, 1-0-1
// (R06) 11h writes status byte three, 1-0-1
// (R07) 92h id read, 1-2-2, four dummies, two bytes
// (R08) 94h id read, 1-4-4, four dummies, two bytes
// (R09) 5Ah parameter table, 1-1-1, eight dummies, streaming
// (R10) chip select release abandons any partial instruction
package sfd_pkg;

	// =========================================================
	// opcodes
	localparam logic [7:0] SFD_OP_RD_SR1  = 8'h05;
	localparam logic [7:0] SFD_OP_RD_SR2  = 8'h35;
	localparam logic [7:0] SFD_OP_RD_SR3  = 8'h15;
	localparam logic [7:0] SFD_OP_WR_SR1  = 8'h01;
	localparam logic [7:0] SFD_OP_WR_SR2  = 8'h31;
	localparam logic [7:0] SFD_OP_WR_SR3  = 8'h11;
	localparam logic [7:0] SFD_OP_ID_DUAL = 8'h92;
	localparam logic [7:0] SFD_OP_ID_QUAD = 8'h94;
	localparam logic [7:0] SFD_OP_PTABLE  = 8'h5A;

	// =========================================================
	// phase geometry
	localparam logic [4:0] SFD_ADDR_BITS  = 5'h18;   // 24 address bits
	localparam logic [4:0] SFD_BYTE_BITS  = 5'h08;
	localparam logic [3:0] SFD_DUMMY_ID   = 4'h4;
	localparam logic [3:0] SFD_DUMMY_PTAB = 4'h8;
	localparam logic [1:0] SFD_LANE_X1    = 2'h0;    // shift amount: log2 of lane count
	localparam logic [1:0] SFD_LANE_X2    = 2'h1;
	localparam logic [1:0] SFD_LANE_X4    = 2'h2;

	// =========================================================
	// data sources and reset values
	localparam logic [1:0] SFD_SRC_STATUS = 2'h0;
	localparam logic [1:0] SFD_SRC_ID     = 2'h1;
	localparam logic [1:0] SFD_SRC_PTAB   = 2'h2;
	localparam logic [7:0] SFD_SR1_RESET  = 8'h00;
	localparam logic [7:0] SFD_SR2_RESET  = 8'h00;
	localparam logic [7:0] SFD_SR3_RESET  = 8'h00;
	localparam logic [7:0] SFD_PTAB_BLANK = 8'hFF;

	// =========================================================
	// carriers
	typedef struct packed {
		logic       valid;      // opcode is handled here
		logic       has_addr;
		logic [1:0] addr_sh;    // lanes of the address phase
		logic [3:0] dummy;      // dummy clocks
		logic [1:0] data_sh;    // lanes of the data phase
		logic       is_write;
		logic [1:0] target;     // status byte index
		logic [1:0] src;        // where read data comes from
	} sfd_cmd_s;

	typedef struct packed {
		logic [1:0] target;
		logic [7:0] data;
	} sfd_swr_s;

	// =========================================================
	// opcode decode
	function automatic sfd_cmd_s sfd_decode(input logic [7:0] opc);
		sfd_cmd_s c;
		c = '{valid: 1'b1, has_addr: 1'b0, addr_sh: SFD_LANE_X1, dummy: 4'h0,
			data_sh: SFD_LANE_X1, is_write: 1'b0, target: 2'h0, src: SFD_SRC_STATUS};
		case (opc)
			SFD_OP_RD_SR1: c.target = 2'h0;                             // R01
			SFD_OP_RD_SR2: c.target = 2'h1;                             // R02
			SFD_OP_RD_SR3: c.target = 2'h2;                             // R03
			SFD_OP_WR_SR1: begin                                        // R04
				c.is_write = 1'b1;
				c.target   = 2'h0;
			end
			SFD_OP_WR_SR2: begin                                        // R05
				c.is_write = 1'b1;
				c.target   = 2'h1;
			end
			SFD_OP_WR_SR3: begin                                        // R06
				c.is_write = 1'b1;
				c.target   = 2'h2;
			end
			SFD_OP_ID_DUAL: begin                                       // R07
				c.has_addr = 1'b1;
				c.addr_sh  = SFD_LANE_X2;
				c.data_sh  = SFD_LANE_X2;
				c.dummy    = SFD_DUMMY_ID;
				c.src      = SFD_SRC_ID;
			end
			SFD_OP_ID_QUAD: begin                                       // R08
				c.has_addr = 1'b1;
				c.addr_sh  = SFD_LANE_X4;
				c.data_sh  = SFD_LANE_X4;
				c.dummy    = SFD_DUMMY_ID;
				c.src      = SFD_SRC_ID;
			end
			SFD_OP_PTABLE: begin                                        // R09
				c.has_addr = 1'b1;
				c.dummy    = SFD_DUMMY_PTAB;
				c.src      = SFD_SRC_PTAB;
			end
			default: c.valid = 1'b0;
		endcase
		return c;
	endfunction

	// parameter table contents: a four-byte signature, then blank
	function automatic logic [7:0] sfd_ptab(input logic [23:0] addr);
		logic [7:0] b;
		b = SFD_PTAB_BLANK;
		if (addr[23:2] == 22'h000000) begin
			case (addr[1:0])
				2'h0:    b = 8'h53;
				2'h1:    b = 8'h46;
				2'h2:    b = 8'h44;
				default: b = 8'h50;
			endcase
		end
		return b;
	endfunction

endpackage

// ---- src/sfd_decoder.sv ----
/*
 * serial flash status / identification command decoder.
 * link side runs on spi_clk; its state and pin registers are held in reset while cs_n is high;
 * status bytes live in the sys_clk domain and are updated through a
 * toggle-and-held-word crossing. outputs toward the pins change on the
 * falling serial clock edge.
 * assumes: host samples data on the rising edge; spi_clk stands still
 * outside frames.
 */
`timescale 1ns/1ns
module sfd_decoder import sfd_pkg::*; #(
	parameter logic [7:0] MFR_ID = 8'hA5,    // arbitrary value
	parameter logic [7:0] DEV_ID = 8'h3C     // arbitrary value
) (
	input  wire logic       sys_clk,       // system clock
	input  wire logic       arst_n,        // async reset, active low
	input  wire logic       spi_clk,       // serial clock from host
	input  wire logic       cs_n,          // chip select, active low
	input  wire logic [3:0] io_in,         // data lines in, io0 is the serial input
	output logic      [3:0] io_out,        // data lines out
	output logic      [3:0] io_oe,         // data line drive enables
	output logic      [7:0] sr1,           // status byte one
	output logic      [7:0] sr2,           // status byte two
	output logic      [7:0] sr3,           // status byte three
	output logic            status_wr      // one sys_clk pulse per status write
);

	// =========================================================
	// link-side declarations
	typedef enum {ST_OPC, ST_ADDR, ST_DUMMY, ST_RDATA, ST_WDATA, ST_SKIP} sfd_state_e;

	sfd_state_e  state_reg, state_next;
	logic [4:0]  cnt_reg, cnt_next;
	logic [23:0] sh_reg, sh_next;          // opcode / address / write byte shifter
	logic [7:0]  tx_reg, tx_next;          // outgoing byte
	logic        idx_reg, idx_next;        // id byte selector
	sfd_cmd_s    cmd_reg, cmd_next;
	sfd_swr_s    swr_reg, swr_next;        // held word toward sys_clk
	logic        tgl_reg, tgl_next;
	logic [3:0]  out_next, oe_next;
	logic        link_rst_n;
	sfd_cmd_s    dec;
	logic [23:0] sh_in;
	logic [7:0]  sr1_reg, sr2_reg, sr3_reg;
	logic [7:0]  lsr1_reg, lsr2_reg, lsr3_reg;   // link-side copies of the status bytes
	logic [7:0]  lsr1_next, lsr2_next, lsr3_next;

	// chip select high clears the link state and pin registers
	assign link_rst_n = arst_n & ~cs_n;                                 // R10

	// shift in the active lanes
	function automatic logic [23:0] shift_in(input logic [23:0] s, input logic [3:0] io,
		input logic [1:0] lsh);
		logic [23:0] r;
		r = {s[22:0], io[0]};
		case (lsh)
			SFD_LANE_X2: r = {s[21:0], io[1:0]};
			SFD_LANE_X4: r = {s[19:0], io[3:0]};
			default:     r = {s[22:0], io[0]};
		endcase
		return r;
	endfunction

	// byte the device returns next
	function automatic logic [7:0] byte_sel(input sfd_cmd_s c, input logic [23:0] a,
		input logic i);
		logic [7:0] b;
		// status bytes come from the link-side copies, so no word crosses clocks here
		b = lsr1_reg;
		case (c.src)
			SFD_SRC_ID:   b = i ? DEV_ID : MFR_ID;                      // R07 R08
			SFD_SRC_PTAB: b = sfd_ptab(a);                              // R09
			default: begin
				case (c.target)
					2'h1:    b = lsr2_reg;                              // R02
					2'h2:    b = lsr3_reg;                              // R03
					default: b = lsr1_reg;                              // R01
				endcase
			end
		endcase
		return b;
	endfunction

	// last cycle index of a phase for a given lane count
	function automatic logic [4:0] last_cnt(input logic [4:0] bits, input logic [1:0] lsh);
		return (bits >> lsh) - 5'h01;
	endfunction

	// =========================================================
	// link state: next values
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg + 5'h01;
		sh_next    = sh_reg;
		tx_next    = tx_reg;
		idx_next   = idx_reg;
		cmd_next   = cmd_reg;
		swr_next   = swr_reg;
		tgl_next   = tgl_reg;
		lsr1_next  = lsr1_reg;
		lsr2_next  = lsr2_reg;
		lsr3_next  = lsr3_reg;
		sh_in      = shift_in(sh_reg, io_in, cmd_reg.addr_sh);
		dec        = sfd_decode({sh_reg[6:0], io_in[0]});
		case (state_reg)
			ST_OPC: begin
				sh_next = {sh_reg[22:0], io_in[0]};
				if (cnt_reg == last_cnt(SFD_BYTE_BITS, SFD_LANE_X1)) begin
					cmd_next = dec;
					cnt_next = 5'h00;
					sh_next  = 24'h000000;
					if (!dec.valid)
						state_next = ST_SKIP;
					else if (dec.has_addr)
						state_next = ST_ADDR;                           // R07 R08 R09
					else if (dec.is_write)
						state_next = ST_WDATA;                          // R04 R05 R06
					else begin
						state_next = ST_RDATA;                          // R01 R02 R03
						tx_next    = byte_sel(dec, 24'h000000, 1'b0);
					end
				end
			end
			ST_ADDR: begin
				sh_next = sh_in;
				if (cnt_reg == last_cnt(SFD_ADDR_BITS, cmd_reg.addr_sh)) begin
					cnt_next   = 5'h00;
					state_next = ST_DUMMY;
				end
			end
			ST_DUMMY: begin
				if (cnt_reg == {1'b0, cmd_reg.dummy - 4'h1}) begin      // R07 R08 R09
					cnt_next   = 5'h00;
					state_next = ST_RDATA;
					tx_next    = byte_sel(cmd_reg, sh_reg, 1'b0);
				end
			end
			ST_RDATA: begin
				tx_next = tx_reg << (5'h01 << cmd_reg.data_sh);
				if (cnt_reg == last_cnt(SFD_BYTE_BITS, cmd_reg.data_sh)) begin
					cnt_next = 5'h00;
					idx_next = ~idx_reg;                                // R07 R08
					sh_next  = sh_reg + 24'h000001;                     // R09
					tx_next  = byte_sel(cmd_reg, sh_reg + 24'h000001, ~idx_reg);
				end
			end
			ST_WDATA: begin
				sh_next = {sh_reg[22:0], io_in[0]};
				if (cnt_reg == last_cnt(SFD_BYTE_BITS, SFD_LANE_X1)) begin
					swr_next   = '{target: cmd_reg.target, data: {sh_reg[6:0], io_in[0]}};
					tgl_next   = ~tgl_reg;                              // R04 R05 R06
					case (cmd_reg.target)
						2'h1:    lsr2_next = {sh_reg[6:0], io_in[0]};   // R05
						2'h2:    lsr3_next = {sh_reg[6:0], io_in[0]};   // R06
						default: lsr1_next = {sh_reg[6:0], io_in[0]};   // R04
					endcase
					state_next = ST_SKIP;
				end
			end
			ST_SKIP: cnt_next = cnt_reg;
			default: state_next = ST_SKIP;
		endcase
	end

	// link state: registers, cleared whenever chip select is released
	always_ff @(posedge spi_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			state_reg <= ST_OPC;                                        // R10
			cnt_reg   <= 5'h00;
			sh_reg    <= 24'h000000;
			tx_reg    <= 8'h00;
			idx_reg   <= 1'b0;
			cmd_reg   <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			sh_reg    <= sh_next;
			tx_reg    <= tx_next;
			idx_reg   <= idx_next;
			cmd_reg   <= cmd_next;
		end
	end

	// write event word, toggle and link copies survive chip select so no event is faked
	always_ff @(posedge spi_clk or negedge arst_n) begin
		if (!arst_n) begin
			swr_reg  <= '0;
			tgl_reg  <= 1'b0;
			lsr1_reg <= SFD_SR1_RESET;
			lsr2_reg <= SFD_SR2_RESET;
			lsr3_reg <= SFD_SR3_RESET;
		end else begin
			swr_reg  <= swr_next;
			tgl_reg  <= tgl_next;
			lsr1_reg <= lsr1_next;
			lsr2_reg <= lsr2_next;
			lsr3_reg <= lsr3_next;
		end
	end

	// =========================================================
	// pin drive: top bits of the outgoing byte on the active lanes
	always_comb begin
		out_next = 4'h0;
		oe_next  = 4'h0;
		if (state_reg == ST_RDATA) begin
			case (cmd_reg.data_sh)
				SFD_LANE_X2: begin
					out_next = {2'h0, tx_reg[7:6]};
					oe_next  = 4'h3;
				end
				SFD_LANE_X4: begin
					out_next = tx_reg[7:4];
					oe_next  = 4'hF;
				end
				default: begin
					out_next = {2'h0, tx_reg[7], 1'b0};                 // serial output on io1
					oe_next  = 4'h2;
				end
			endcase
		end
	end

	// pin drive registers, updated on the falling edge
	always_ff @(negedge spi_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			io_out <= 4'h0;
			io_oe  <= 4'h0;                                             // R10
		end else begin
			io_out <= out_next;
			io_oe  <= oe_next;
		end
	end

	// =========================================================
	// system side: toggle synchroniser and status bytes
	logic       sync1_reg, sync2_reg, sync3_reg;
	logic [7:0] sr1_next, sr2_next, sr3_next;
	logic       wr_evt, status_wr_next;

	// capture the held word once the toggle has crossed
	always_comb begin
		wr_evt         = sync2_reg ^ sync3_reg;
		sr1_next       = sr1_reg;
		sr2_next       = sr2_reg;
		sr3_next       = sr3_reg;
		status_wr_next = wr_evt;
		if (wr_evt) begin
			case (swr_reg.target)
				2'h1:    sr2_next = swr_reg.data;                       // R05
				2'h2:    sr3_next = swr_reg.data;                       // R06
				default: sr1_next = swr_reg.data;                       // R04
			endcase
		end
	end

	// system side registers
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg     <= 1'b0;
			sync2_reg     <= 1'b0;
			sync3_reg     <= 1'b0;
			sr1_reg       <= SFD_SR1_RESET;
			sr2_reg       <= SFD_SR2_RESET;
			sr3_reg       <= SFD_SR3_RESET;
			status_wr     <= 1'b0;
		end else begin
			sync1_reg     <= tgl_reg;
			sync2_reg     <= sync1_reg;
			sync3_reg     <= sync2_reg;
			sr1_reg       <= sr1_next;
			sr2_reg       <= sr2_next;
			sr3_reg       <= sr3_next;
			status_wr     <= status_wr_next;
		end
	end

	assign sr1 = sr1_reg;
	assign sr2 = sr2_reg;
	assign sr3 = sr3_reg;

endmodule // sfd_decoder

// ---- testbench/sfd_decoder_props.sv ----
/*
 * checker for the command decoder: lane enables per opcode and the data bits of status byte one.
 * assumes: spi mode 0, spi_clk still while cs_n is high.
 */
`timescale 1ns/1ns
module sfd_decoder_props (
	input wire logic       sys_clk,   // system clock
	input wire logic       arst_n,    // async reset, active low
	input wire logic       spi_clk,   // serial clock
	input wire logic       cs_n,      // chip select
	input wire logic [3:0] io_in,     // lines in
	input wire logic [3:0] io_out,    // lines out
	input wire logic [3:0] io_oe,     // drive enables
	input wire logic [7:0] sr1,       // status byte one
	input wire logic [7:0] sr2,       // status byte two
	input wire logic [7:0] sr3,       // status byte three
	input wire logic       status_wr  // write pulse
);
	// =========================================================
	// frame tracking
	logic [7:0] cnt_reg;  // rising edges seen in this frame
	logic [7:0] op_reg;   // opcode gathered on io0
	// count edges and gather the opcode, cleared by chip select
	always_ff @(posedge spi_clk or posedge cs_n) begin
		if (cs_n) begin
			cnt_reg <= 8'h00;
			op_reg  <= 8'h00;
		end else begin
			if (cnt_reg != 8'hFF)
				cnt_reg <= cnt_reg + 8'h01;
			if (cnt_reg < 8'h08)
				op_reg <= {op_reg[6:0], io_in[0]};
		end
	end
	// =========================================================
	// assertions
	a_cs_idle_quiet: assert property (@(posedge sys_clk) disable iff (!arst_n)
		cs_n && $past(cs_n) |-> io_oe == 4'h0) else $error("lines driven outside a frame");
	a_opcode_quiet: assert property (@(posedge spi_clk) disable iff (!arst_n || cs_n)
		cnt_reg < 8'h08 |-> io_oe == 4'h0) else $error("lines driven during opcode");
	a_status_lane: assert property (@(posedge spi_clk) disable iff (!arst_n || cs_n)
		cnt_reg >= 8'h08 && (op_reg == 8'h05 || op_reg == 8'h35 || op_reg == 8'h15)
		|-> io_oe == 4'h2) else $error("status read lane wrong");
	a_sr1_bits: assert property (@(posedge spi_clk) disable iff (!arst_n || cs_n)
		cnt_reg >= 8'h08 && op_reg == 8'h05 |-> io_out[1] == sr1[~cnt_reg[2:0]]) else $error("status bit wrong");
	a_write_silent: assert property (@(posedge spi_clk) disable iff (!arst_n || cs_n)
		cnt_reg >= 8'h08 && (op_reg == 8'h01 || op_reg == 8'h31 || op_reg == 8'h11)
		|-> io_oe == 4'h0) else $error("lines driven during write");
	a_id_dual_lane: assert property (@(posedge spi_clk) disable iff (!arst_n || cs_n)
		cnt_reg >= 8'h08 && op_reg == 8'h92 |-> io_oe == (cnt_reg >= 8'd24 ? 4'h3 : 4'h0))
		else $error("dual id phase wrong");
	a_id_quad_lane: assert property (@(posedge spi_clk) disable iff (!arst_n || cs_n)
		cnt_reg >= 8'h08 && op_reg == 8'h94 |-> io_oe == (cnt_reg >= 8'd18 ? 4'hF : 4'h0))
		else $error("quad id phase wrong");
	a_ptab_lane: assert property (@(posedge spi_clk) disable iff (!arst_n || cs_n)
		cnt_reg >= 8'h08 && op_reg == 8'h5A |-> io_oe == (cnt_reg >= 8'd40 ? 4'h2 : 4'h0))
		else $error("table read phase wrong");
	a_wr_one_pulse: assert property (@(posedge sys_clk) disable iff (!arst_n)
		status_wr |=> !status_wr) else $error("write pulse too long");
	// main scenarios reached
	c_quad: cover property (@(posedge spi_clk) op_reg == 8'h94 && cnt_reg == 8'd18);
	c_ptab: cover property (@(posedge spi_clk) op_reg == 8'h5A && cnt_reg == 8'd41);
	c_write: cover property (@(posedge sys_clk) status_wr);
endmodule // sfd_decoder_props

// ---- testbench/sfd_host.sv ----
/*
 * host controller model: frames in spi mode 0, msb first.
 * assumes: the bench calls xfer; released lines flip every cycle;
 * a line the device does not drive reads as the inverse of its last value.
 */
`timescale 1ns/1ns
module sfd_host (
	output logic            spi_clk,  // serial clock, still between frames
	output logic            cs_n,     // chip select, active low
	output logic      [3:0] io_in,    // lines toward the device
	input  wire logic [3:0] io_out,   // lines from the device
	input  wire logic [3:0] io_oe     // device drive enables
);
	logic [3:0] oe_seen;  // enables at the last rising edge
	logic [3:0] lines;    // levels last seen on the device lines
	int         n;        // edges in this frame
	int         stop;     // cut the frame after this many edges, 0 none
	// idle levels
	initial begin
		spi_clk = 1'b0;
		cs_n    = 1'b1;
		io_in   = 4'h0;
		stop    = 0;
		oe_seen = 4'h0;
		lines   = 4'h0;
	end
	// one clock period: change after the falling edge, sample at the rising
	task automatic tick(input logic [3:0] v, output logic [3:0] s);
		n++;
		s = 4'h0;
		if (stop == 0 || n <= stop) begin
			io_in = v;
			#62 spi_clk = 1'b1;
			s       = (io_out & io_oe) | (~lines & ~io_oe);
			lines   = s;
			oe_seen = io_oe;
			#63 spi_clk = 1'b0;
		end
	endtask
	// opcode, ne host edges on al lanes, dummies, nb bytes read on dl lanes
	task automatic xfer(input logic [7:0] op, input int al, input int ne, input int dum, input int dl,
		input int nb, input logic [23:0] ad, output logic [31:0] rd);
		logic [3:0] s;
		n    = 0;
		rd   = 32'h0;
		cs_n = 1'b0;
		#63;
		for (int i = 7; i >= 0; i--)
			tick({~io_in[3:1], op[i]}, s);
		for (int i = ne - 1; i >= 0; i--)
			tick(al == 4 ? ad[i*4+:4] : al == 2 ? {~io_in[3:2], ad[i*2+:2]} : {~io_in[3:1], ad[i]}, s);
		for (int i = 0; i < dum; i++)
			tick(~io_in, s);
		for (int i = 0; i < nb * 8 / dl; i++) begin
			tick(~io_in, s);
			rd = (rd << dl) | 32'(dl == 4 ? s : dl == 2 ? {2'h0, s[1:0]} : {3'h0, s[1]});
		end
		cs_n = 1'b1;
		stop = 0;
		#250;
	endtask
endmodule // sfd_host

// ---- testbench/sfd_decoder_tb.sv ----
/*
 * self-checking bench for the command decoder.
 * assumes: host model drives the link at 125 ns, unrelated to sys_clk.
 */
`timescale 1ns/1ns
module sfd_decoder_tb;
	import sfd_pkg::*;
	localparam logic [7:0] ID_M = 8'h5E;  // arbitrary value
	localparam logic [7:0] ID_D = 8'h71;  // arbitrary value
	logic        sys_clk, arst_n, status_wr;
	wire         spi_clk, cs_n;
	wire  [3:0]  io_in;
	logic [3:0]  io_out, io_oe;
	logic [7:0]  sr1, sr2, sr3;
	logic [31:0] rd;
	int          num_errors, num_checks, pulses;
	// =========================================================
	// instances
	sfd_decoder #(.MFR_ID(ID_M), .DEV_ID(ID_D)) dut (.sys_clk(sys_clk), .arst_n(arst_n), .spi_clk(spi_clk),
		.cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .sr1(sr1), .sr2(sr2), .sr3(sr3),
		.status_wr(status_wr));
	sfd_host host (.spi_clk(spi_clk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
	// clock and write pulse counter
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) if (status_wr === 1'b1) pulses++;
	// =========================================================
	// checking
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// =========================================================
	// scenarios
	task automatic t_status();
		logic [7:0] wop[3] = '{8'h01, 8'h31, 8'h11};
		logic [7:0] rop[3] = '{8'h05, 8'h35, 8'h15};
		logic [7:0] val[3] = '{8'hA6, 8'h81, 8'h3C};
		int p;
		for (int i = 0; i < 3; i++) begin
			p = pulses;
			host.xfer(wop[i], 1, 8, 0, 1, 0, {16'h0, val[i]}, rd);
			repeat (10) @(negedge sys_clk);
			chk(32'(pulses - p), 32'h1);
			chk({24'h0, i == 0 ? sr1 : i == 1 ? sr2 : sr3}, {24'h0, val[i]});
			host.xfer(rop[i], 0, 0, 0, 1, 2, 24'h0, rd);
			chk(rd, {16'h0, val[i], val[i]});
			chk({28'h0, host.oe_seen}, 32'h2);
		end
		$display("status test done");
	endtask
	task automatic t_id();
		host.xfer(SFD_OP_ID_DUAL, 2, 12, 4, 2, 3, 24'h123456, rd);
		chk(rd, {8'h0, ID_M, ID_D, ID_M});
		chk({28'h0, host.oe_seen}, 32'h3);
		host.xfer(SFD_OP_ID_QUAD, 4, 6, 4, 4, 2, 24'hABCDEF, rd);
		chk(rd, {16'h0, ID_M, ID_D});
		chk({28'h0, host.oe_seen}, 32'hF);
		host.xfer(SFD_OP_PTABLE, 1, 24, 8, 1, 3, 24'h000002, rd);
		chk(rd, 32'h004450FF);
		chk({28'h0, host.oe_seen}, 32'h2);
		$display("id test done");
	endtask
	task automatic t_abort();
		int p;
		p = pulses;
		host.stop = 12;
		host.xfer(8'h01, 1, 8, 0, 1, 0, 24'h00005A, rd);
		host.stop = 30;
		host.xfer(SFD_OP_PTABLE, 1, 24, 8, 1, 1, 24'h0, rd);
		repeat (10) @(negedge sys_clk);
		chk(32'(pulses - p), 32'h0);
		host.xfer(8'h05, 0, 0, 0, 1, 1, 24'h0, rd);
		chk(rd, 32'h000000A6);
		host.xfer(8'h9F, 0, 0, 0, 1, 2, 24'h0, rd);
		chk({28'h0, host.oe_seen}, 32'h0);
		$display("abort test done");
	endtask
	// =========================================================
	// main sequence and watchdog
	initial begin
		num_errors = 0;
		num_checks = 0;
		pulses     = 0;
		arst_n     = 1'b0;
		repeat (12) @(negedge sys_clk);
		arst_n = 1'b1;
		@(negedge sys_clk);
		t_status();
		t_id();
		t_abort();
		report_and_stop();
	end
	initial begin
		#500000;
		num_errors++;
		report_and_stop();
	end
endmodule // sfd_decoder_tb
bind sfd_decoder sfd_decoder_props u_props (.sys_clk(sys_clk), .arst_n(arst_n), .spi_clk(spi_clk), .cs_n(cs_n),
	.io_in(io_in), .io_out(io_out), .io_oe(io_oe), .sr1(sr1), .sr2(sr2), .sr3(sr3), .status_wr(status_wr));
